// ===== rtl/dpmb_axil_regs.sv
// AXI4-Lite slave holding the command, address, data and status registers.
// Assumes one clock; the access sequencer reports completion as one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module dpmb_axil_regs
  import dpmb_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic cmdValid,
  output logic [2:0] cmdOp,
  output logic [ADDR_W-1:0] cmdAddr,
  output logic [DATA_W-1:0] cmdWdata,
  input wire logic opBusy,
  input wire logic opDone,
  input wire logic collEvent,
  input wire logic irqActive,
  input wire logic grant,
  input wire logic [DATA_W-1:0] rdByte
);
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic awHeldQ, wHeldQ, doneQ, collQ;
  logic doWrite;
  logic clrDone, clrColl;

  assign doWrite = awHeldQ && wHeldQ && !bvalid;
  assign clrDone = doWrite && awAddrQ == REG_STATUS && wStrbQ[0] && wDataQ[ST_BIT_DONE];
  assign clrColl = doWrite && awAddrQ == REG_STATUS && wStrbQ[0] && wDataQ[ST_BIT_COLL];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awready <= !awHeldQ && !(awvalid && awready) && !bvalid;
      wready <= !wHeldQ && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        awHeldQ <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wHeldQ <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        awHeldQ <= 1'b0;
        wHeldQ <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awAddrQ == REG_CMD || awAddrQ == REG_ADDR || awAddrQ == REG_WDATA ||
                  awAddrQ == REG_STATUS || awAddrQ == REG_RDATA) ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmdValid <= 1'b0;
      cmdOp <= OP_MEM_RD;
      cmdAddr <= '0;
      cmdWdata <= '0;
    end else begin
      cmdValid <= doWrite && awAddrQ == REG_CMD && wStrbQ[0] && !opBusy;
      if (doWrite && awAddrQ == REG_CMD && wStrbQ[0] && !opBusy) begin
        cmdOp <= wDataQ[2:0];
      end
      if (doWrite && awAddrQ == REG_ADDR && !opBusy) begin
        if (wStrbQ[0]) cmdAddr[7:0] <= wDataQ[7:0];
        if (wStrbQ[1]) cmdAddr[ADDR_W-1:8] <= wDataQ[ADDR_W-1:8];
      end
      if (doWrite && awAddrQ == REG_WDATA && wStrbQ[0] && !opBusy) begin
        cmdWdata <= wDataQ[DATA_W-1:0];
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle wins.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      doneQ <= 1'b0;
      collQ <= 1'b0;
    end else begin
      doneQ <= opDone || (doneQ && !clrDone);
      collQ <= collEvent || (collQ && !clrColl);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= RESP_OKAY;
        rdata <= 32'h0000_0000;
        case (araddr)
          REG_CMD: rdata[2:0] <= cmdOp;
          REG_ADDR: rdata[ADDR_W-1:0] <= cmdAddr;
          REG_WDATA: rdata[DATA_W-1:0] <= cmdWdata;
          REG_RDATA: rdata[DATA_W-1:0] <= rdByte;
          REG_STATUS: begin
            rdata[ST_BIT_BUSY] <= opBusy;
            rdata[ST_BIT_DONE] <= doneQ;
            rdata[ST_BIT_IRQ] <= irqActive;
            rdata[ST_BIT_COLL] <= collQ;
            rdata[ST_BIT_GRANT] <= grant;
          end
          default: rresp <= RESP_DECERR;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : dpmb_axil_regs
`default_nettype wire

// ===== rtl/dpmb_end.sv
// Closing file of the design list; it holds no logic.
// Assumes nothing of its surroundings.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== rtl/dpmb_pkg.sv
// Constants, encodings and register map for the dual-port mailbox host controller.
// Assumes a 10 MHz clock and one port of an asynchronous dual-port memory on the pins.
// Contract
// - Right host clears its interrupt by reading the top address; device releases it.
// - Depth expansion ANDs the collision outputs of all devices together.
// - A host seeing collision stalls its access until the other side finishes; the controller stalls only memory accesses, never flag accesses.
// - Flag access uses chip select high and flag select low; memory the opposite.
package dpmb_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int FLAG_IDX_W = 3;
  localparam logic [ADDR_W-1:0] MBOX_LEFT = 15'h7FFE;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT = 15'h7FFF;

  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam logic [2:0] OP_MEM_RD = 3'h0;
  localparam logic [2:0] OP_MEM_WR = 3'h1;
  localparam logic [2:0] OP_FLAG_RD = 3'h2;
  localparam logic [2:0] OP_FLAG_WR = 3'h3;
  localparam logic [2:0] OP_MBOX_SEND = 3'h4;
  localparam logic [2:0] OP_MBOX_CLR = 3'h5;
  localparam logic [2:0] OP_FLAG_TAKE = 3'h6;

  localparam int ST_BIT_BUSY = 0;
  localparam int ST_BIT_DONE = 1;
  localparam int ST_BIT_IRQ = 2;
  localparam int ST_BIT_COLL = 3;
  localparam int ST_BIT_GRANT = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam int CLK_HZ = 10000000;
  localparam int STROBE_NS = 55;
  localparam int STROBE_CYC_RAW = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RELEASE} dpmb_state_t;
endpackage : dpmb_pkg

// ===== rtl/dpmb_port_ctrl.sv
// Host controller for one port of a dual-port memory with mailboxes and flags.
// Assumes pin inputs synchronous to the clock and device access times under one period.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module dpmb_port_ctrl
  import dpmb_pkg::*;
#(
  parameter bit LEFT_PORT = 1'b1,
  parameter int NBUSY = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [ADDR_W-1:0] memAddr,
  output logic chipSelN,
  output logic flag_space_select_n,
  output logic outEnN,
  output logic readWriteN,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic [NBUSY-1:0] collisionInN,
  input wire logic mailboxIrqN
);
  localparam logic [ADDR_W-1:0] OWN_MBOX = LEFT_PORT ? MBOX_LEFT : MBOX_RIGHT;
  localparam logic [ADDR_W-1:0] PEER_MBOX = LEFT_PORT ? MBOX_RIGHT : MBOX_LEFT;

  dpmb_state_t stateQ;
  logic [2:0] opQ;
  logic phaseQ;
  logic [7:0] cntQ;
  logic [DATA_W-1:0] rdByteQ;
  logic doneQ, collEvQ, grantQ, irqQ;
  logic cmdValid;
  logic [2:0] cmdOp;
  logic [ADDR_W-1:0] cmdAddr;
  logic [DATA_W-1:0] cmdWdata;
  logic busyN, isFlag, isWrite, stalled;
  logic [ADDR_W-1:0] pinAddr;
  logic [DATA_W-1:0] pinData;

  assign busyN = &collisionInN;
  assign isFlag = opQ == OP_FLAG_RD || opQ == OP_FLAG_WR || opQ == OP_FLAG_TAKE;
  assign isWrite = opQ == OP_MEM_WR || opQ == OP_FLAG_WR || opQ == OP_MBOX_SEND ||
                   (opQ == OP_FLAG_TAKE && !phaseQ);
  assign stalled = !busyN && !isFlag;

  always_comb begin
    pinAddr = cmdAddr;
    pinData = cmdWdata;
    case (opQ)
      OP_MBOX_SEND: pinAddr = PEER_MBOX;
      OP_MBOX_CLR: pinAddr = OWN_MBOX;
      OP_FLAG_RD, OP_FLAG_WR, OP_FLAG_TAKE: begin
        pinAddr = {{(ADDR_W-FLAG_IDX_W){1'b0}}, cmdAddr[FLAG_IDX_W-1:0]};
        pinData = {{(DATA_W-1){1'b0}}, (opQ == OP_FLAG_WR) ? cmdWdata[0] : 1'b0};
      end
      default: begin
        pinAddr = cmdAddr;
        pinData = cmdWdata;
      end
    endcase
  end

  dpmb_axil_regs u_regs (
    .clock(clock),
    .rst_n(rst_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .cmdValid(cmdValid),
    .cmdOp(cmdOp),
    .cmdAddr(cmdAddr),
    .cmdWdata(cmdWdata),
    .opBusy(stateQ != ST_IDLE || cmdValid),
    .opDone(doneQ),
    .collEvent(collEvQ),
    .irqActive(irqQ),
    .grant(grantQ),
    .rdByte(rdByteQ)
  );

  // Access sequencer: setup, strobe (stretched while collision is low, except on flag accesses), release.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stateQ <= ST_IDLE;
      opQ <= OP_MEM_RD;
      phaseQ <= 1'b0;
      cntQ <= 8'h00;
    end else begin
      case (stateQ)
        ST_IDLE: begin
          phaseQ <= 1'b0;
          if (cmdValid) begin
            opQ <= cmdOp;
            stateQ <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cntQ <= 8'h00;
          stateQ <= ST_STROBE;
        end
        ST_STROBE: begin
          if (stalled) begin
            cntQ <= 8'h00;
          end else if (cntQ == STROBE_LAST) begin
            stateQ <= ST_RELEASE;
          end else begin
            cntQ <= cntQ + 8'h01;
          end
        end
        ST_RELEASE: begin
          if (opQ == OP_FLAG_TAKE && !phaseQ) begin
            phaseQ <= 1'b1;
            stateQ <= ST_SETUP;
          end else begin
            stateQ <= ST_IDLE;
          end
        end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  // Pin drive; idle keeps both selects high so the port is in standby.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      memAddr <= '0;
      chipSelN <= 1'b1;
      flag_space_select_n <= 1'b1;
      outEnN <= 1'b1;
      readWriteN <= 1'b1;
      dataOut <= '0;
      dataOe <= 1'b0;
    end else begin
      case (stateQ)
        ST_SETUP: begin
          memAddr <= pinAddr;
          chipSelN <= isFlag;
          flag_space_select_n <= !isFlag;
          dataOut <= pinData;
          dataOe <= isWrite;
          readWriteN <= !isWrite;
          outEnN <= isWrite;
        end
        ST_STROBE: begin
          if (!stalled && cntQ == STROBE_LAST) begin
            chipSelN <= 1'b1;
            flag_space_select_n <= 1'b1;
            outEnN <= 1'b1;
            readWriteN <= 1'b1;
            dataOe <= 1'b0;
          end
        end
        default: begin
          chipSelN <= 1'b1;
          flag_space_select_n <= 1'b1;
          outEnN <= 1'b1;
          readWriteN <= 1'b1;
          dataOe <= 1'b0;
        end
      endcase
    end
  end

  // Read capture, grant result, completion and collision events.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdByteQ <= '0;
      grantQ <= 1'b0;
      doneQ <= 1'b0;
      collEvQ <= 1'b0;
      irqQ <= 1'b0;
    end else begin
      irqQ <= !mailboxIrqN;
      collEvQ <= stateQ == ST_STROBE && !busyN;
      doneQ <= stateQ == ST_RELEASE && !(opQ == OP_FLAG_TAKE && !phaseQ);
      if (stateQ == ST_STROBE && !stalled && cntQ == STROBE_LAST && !isWrite) begin
        rdByteQ <= dataIn;
        if (opQ == OP_FLAG_TAKE) grantQ <= !dataIn[0];
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_readEnd;
    stateQ == ST_STROBE && !outEnN && !stalled && cntQ == STROBE_LAST;
  endsequence
  sequence s_allReleased;
    outEnN && flag_space_select_n && chipSelN && readWriteN;
  endsequence
  sequence s_takeWrite;
    stateQ == ST_STROBE && opQ == OP_FLAG_TAKE && !readWriteN;
  endsequence

  property p_flagSpace;
    !flag_space_select_n |-> chipSelN;
  endproperty
  a_flagSpace: assert property (p_flagSpace) else $error("flag select with chip select");
  property p_memSpace;
    !chipSelN |-> flag_space_select_n;
  endproperty
  a_memSpace: assert property (p_memSpace) else $error("chip select with flag select");
  property p_flagIndex;
    !flag_space_select_n |-> memAddr[ADDR_W-1:FLAG_IDX_W] == '0;
  endproperty
  a_flagIndex: assert property (p_flagIndex) else $error("flag address out of range");
  property p_stall;
    (stateQ == ST_STROBE && !busyN && !isFlag) |=> stateQ == ST_STROBE && !chipSelN;
  endproperty
  a_stall: assert property (p_stall) else $error("access ended during collision");
  property p_send;
    (stateQ == ST_STROBE && opQ == OP_MBOX_SEND) |-> memAddr == PEER_MBOX && !readWriteN;
  endproperty
  a_send: assert property (p_send) else $error("mailbox send wrong address");
  property p_clear;
    (stateQ == ST_STROBE && opQ == OP_MBOX_CLR) |->
      memAddr == OWN_MBOX && !outEnN && !chipSelN && readWriteN;
  endproperty
  a_clear: assert property (p_clear) else $error("mailbox clear not a read");
  property p_clearWait;
    (stateQ == ST_STROBE && opQ == OP_MBOX_CLR && !busyN) |=> !outEnN;
  endproperty
  a_clearWait: assert property (p_clearWait) else $error("clear left before busy high");
  property p_release;
    s_readEnd |=> s_allReleased ##1 s_allReleased;
  endproperty
  a_release: assert property (p_release) else $error("strobes not released after read");
  property p_takeZero;
    s_takeWrite |-> dataOe && !dataOut[0] ##[1:8] (stateQ == ST_STROBE && readWriteN);
  endproperty
  a_takeZero: assert property (p_takeZero) else $error("flag take sequence broken");
  property p_standby;
    stateQ == ST_IDLE |-> chipSelN && flag_space_select_n && !dataOe;
  endproperty
  a_standby: assert property (p_standby) else $error("port selected while idle");
endmodule : dpmb_port_ctrl
`default_nettype wire

// ===== tb/dpmb_dev_model.sv
// Behavioural dual-port memory with mailboxes, collision flags and eight token flags.
// Assumes the left pins come from the controller and the right pins from the bench.
`timescale 1ns/1ns
`default_nettype none
module dpmb_dev_model
  import dpmb_pkg::*;
(
  input wire logic clock,
  input wire logic [ADDR_W-1:0] lAddr,
  input wire logic lCsN,
  input wire logic lFlagN,
  input wire logic lOeN,
  input wire logic lRwN,
  input wire logic [DATA_W-1:0] lBus,
  output logic [DATA_W-1:0] lOut,
  output logic lCollN,
  output logic lIrqN,
  input wire logic [ADDR_W-1:0] rAddr,
  input wire logic rCsN,
  input wire logic rFlagN,
  input wire logic rOeN,
  input wire logic rRwN,
  input wire logic [DATA_W-1:0] rIn,
  output logic [DATA_W-1:0] rOut,
  output logic rIrqN,
  input wire logic masterSel,
  input wire logic slaveBusyLN
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [1:0] holder [8];
  logic [7:0] pend [1:2];
  logic [DATA_W-1:0] lLat, rLat, lLast;
  logic irqLeft, irqRight, rFirst;
  wire logic lRd = lFlagN | lOeN;
  wire logic rRd = rFlagN | rOeN;
  wire logic coll = !lCsN && !rCsN && lAddr == rAddr;

  task automatic flagWr(input int s, input int i, input logic b);
    if (!b && holder[i] == 2'h0) holder[i] = 2'(s);
    else if (!b && holder[i] != 2'(s)) pend[s][i] = 1'b1;
    else if (b && holder[i] == 2'(s)) begin
      holder[i] = pend[3-s][i] ? 2'(3 - s) : 2'h0;
      pend[3-s][i] = 1'b0;
    end else if (b) pend[s][i] = 1'b0;
  endtask : flagWr

  initial begin
    irqLeft = 1'b0;
    irqRight = 1'b0;
    rFirst = 1'b0;
    lLast = '0;
    pend[1] = '0;
    pend[2] = '0;
    for (int i = 0; i < 8; i++) holder[i] = 2'h0;
  end

  assign lCollN = masterSel ? !(coll && rFirst) : slaveBusyLN;
  assign lIrqN = !irqLeft;
  assign rIrqN = !irqRight;
  assign rOut = !rFlagN ? rLat : mem[rAddr];

  always @(posedge clock) if (lCsN) rFirst <= !rCsN;
  always @(negedge lRd) lLat <= {DATA_W{holder[lAddr[2:0]] != 2'h1}};
  always @(negedge rRd) rLat <= {DATA_W{holder[rAddr[2:0]] != 2'h2}};

  always_comb begin
    if (!lCsN && !lOeN && lRwN) lOut = mem[lAddr];
    else if (!lFlagN && !lOeN && lRwN) lOut = lLat;
    else lOut = ~lLast;
  end

  always @(posedge clock) begin
    lLast <= lBus;
    if (!lCsN && !lRwN && lCollN) begin
      mem[lAddr] <= lBus;
      if (lAddr == MBOX_RIGHT) irqRight <= 1'b1;
    end
    if (!lCsN && !lOeN && lAddr == MBOX_LEFT && lCollN) irqLeft <= 1'b0;
    if (!rCsN && !rRwN) begin
      mem[rAddr] <= rIn;
      if (rAddr == MBOX_LEFT) irqLeft <= 1'b1;
    end
    if (!rCsN && !rOeN && rAddr == MBOX_RIGHT) irqRight <= 1'b0;
    if (lCsN && !lFlagN && !lRwN) flagWr(1, lAddr[2:0], lBus[0]);
    if (rCsN && !rFlagN && !rRwN) flagWr(2, rAddr[2:0], rIn[0]);
  end
endmodule : dpmb_dev_model
`default_nettype wire

// ===== tb/test_dual_port_mailbox_arbiter.sv
// Self-checking bench for the port controller driving a behavioural dual-port memory.
// Assumes the controller is the left port; the bench plays the right-hand host.
`timescale 1ns/1ns
`default_nettype none
module test_dual_port_mailbox_arbiter
  import dpmb_pkg::*;
;
  typedef struct {
    logic [2:0] op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wd;
    logic [7:0] exp;
    logic chkRd;
    logic irqR;
  } dpmb_row_t;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, st;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [ADDR_W-1:0] memAddr, rAddr;
  logic chipSelN, flagSelN, outEnN, readWriteN, dataOe, collN, irqN;
  logic rCsN, rFlagN, rOeN, rRwN, rIrqN;
  logic masterSel, slaveBusyLN;
  logic [7:0] dataOut, dataIn, devOut, rIn, rOut, rSeen;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  dpmb_row_t rows [12] = '{
    '{OP_MEM_WR, 15'h0123, 8'hA5, 8'h00, 1'b0, 1'b1},
    '{OP_MEM_RD, 15'h0123, 8'h00, 8'hA5, 1'b1, 1'b1},
    '{OP_MEM_WR, 15'h7FFF, 8'h3C, 8'h00, 1'b0, 1'b0},
    '{OP_MEM_RD, 15'h7FFF, 8'h00, 8'h3C, 1'b1, 1'b0},
    '{OP_FLAG_WR, 15'h0002, 8'h00, 8'h00, 1'b0, 1'b0},
    '{OP_FLAG_RD, 15'h0002, 8'h00, 8'h00, 1'b1, 1'b0},
    '{OP_FLAG_WR, 15'h0002, 8'h01, 8'h00, 1'b0, 1'b0},
    '{OP_FLAG_RD, 15'h0002, 8'h00, 8'hFF, 1'b1, 1'b0},
    '{OP_MBOX_SEND, 15'h0000, 8'h5A, 8'h00, 1'b0, 1'b0},
    '{OP_MEM_RD, 15'h7FFF, 8'h00, 8'h5A, 1'b1, 1'b0},
    '{OP_FLAG_TAKE, 15'h0005, 8'h00, 8'h00, 1'b1, 1'b0},
    '{OP_FLAG_WR, 15'h0005, 8'h01, 8'h00, 1'b0, 1'b0}};

  assign dataIn = dataOe ? dataOut : devOut;

  dpmb_port_ctrl #(.LEFT_PORT(1'b1), .NBUSY(1)) DUT (
    .clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .memAddr(memAddr), .chipSelN(chipSelN), .flag_space_select_n(flagSelN),
    .outEnN(outEnN), .readWriteN(readWriteN), .dataOut(dataOut), .dataOe(dataOe),
    .dataIn(dataIn), .collisionInN(collN), .mailboxIrqN(irqN));

  dpmb_dev_model DEV (
    .clock(clock), .lAddr(memAddr), .lCsN(chipSelN), .lFlagN(flagSelN), .lOeN(outEnN),
    .lRwN(readWriteN), .lBus(dataIn), .lOut(devOut), .lCollN(collN), .lIrqN(irqN),
    .rAddr(rAddr), .rCsN(rCsN), .rFlagN(rFlagN), .rOeN(rOeN), .rRwN(rRwN), .rIn(rIn),
    .rOut(rOut), .rIrqN(rIrqN), .masterSel(masterSel), .slaveBusyLN(slaveBusyLN));

  task automatic give_verdict();
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t: value %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axW(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] eb = RESP_OKAY);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check(bresp, eb);
    bready <= 1'b0;
  endtask : axW

  task automatic axR(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axR

  task automatic startOp(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    axW(REG_ADDR, {17'h0_0000, a});
    axW(REG_WDATA, {24'h00_0000, d});
    axW(REG_CMD, {29'h0000_0000, op});
  endtask : startOp

  task automatic finishOp();
    do begin
      axR(REG_STATUS, st, resp);
    end while (!st[ST_BIT_DONE]);
    axR(REG_RDATA, rd, resp);
    axW(REG_STATUS, 32'h0000_000A);
  endtask : finishOp

  task automatic runOp(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    startOp(op, a, d);
    finishOp();
  endtask : runOp

  task automatic rSet(input logic [ADDR_W-1:0] a, input logic flag, input logic wr,
      input logic [7:0] d);
    @(posedge clock);
    rAddr <= a;
    rCsN <= flag;
    rFlagN <= !flag;
    rRwN <= !wr;
    rOeN <= wr;
    rIn <= d;
  endtask : rSet

  task automatic rRel();
    @(posedge clock);
    rCsN <= 1'b1;
    rFlagN <= 1'b1;
    rRwN <= 1'b1;
    rOeN <= 1'b1;
  endtask : rRel

  task automatic rAcc(input logic [ADDR_W-1:0] a, input logic flag, input logic wr,
      input logic [7:0] d);
    rSet(a, flag, wr, d);
    repeat (2) @(posedge clock);
    rSeen = rOut;
    rRel();
  endtask : rAcc

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, rAddr, rIn} = '0;
    {rCsN, rFlagN, rOeN, rRwN} = 4'hF;
    {masterSel, slaveBusyLN} = 2'h3;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      runOp(rows[i].op, rows[i].addr, rows[i].wd);
      if (rows[i].chkRd) check(rd[7:0], rows[i].exp);
      check(rIrqN, rows[i].irqR);
    end
    axR(8'h20, rd, resp);
    check(resp, RESP_DECERR);
    axW(8'h20, 32'h0000_0001, RESP_DECERR);
    rAcc(MBOX_LEFT, 1'b0, 1'b1, 8'h66);
    repeat (3) @(posedge clock);
    axR(REG_STATUS, st, resp);
    check(st[ST_BIT_IRQ], 1'b1);
    rSet(MBOX_LEFT, 1'b0, 1'b0, 8'h00);
    startOp(OP_MBOX_CLR, 15'h0000, 8'h00);
    repeat (8) @(posedge clock);
    check(irqN, 1'b0);
    rRel();
    finishOp();
    check(rd[7:0], 8'h66);
    axR(REG_STATUS, st, resp);
    check(st[ST_BIT_IRQ], 1'b0);
    rAcc(MBOX_RIGHT, 1'b0, 1'b0, 8'h00);
    check(rIrqN, 1'b1);
    rSet(15'h0123, 1'b0, 1'b0, 8'h00);
    startOp(OP_MEM_WR, 15'h0123, 8'h77);
    repeat (8) @(posedge clock);
    check(DEV.mem[15'h0123], 8'hA5);
    axR(REG_STATUS, st, resp);
    check(st[ST_BIT_BUSY], 1'b1);
    check(st[ST_BIT_COLL], 1'b1);
    rRel();
    finishOp();
    check(DEV.mem[15'h0123], 8'h77);
    masterSel <= 1'b0;
    slaveBusyLN <= 1'b0;
    startOp(OP_MEM_WR, 15'h0123, 8'h99);
    repeat (8) @(posedge clock);
    check(DEV.mem[15'h0123], 8'h77);
    slaveBusyLN <= 1'b1;
    finishOp();
    check(DEV.mem[15'h0123], 8'h99);
    masterSel <= 1'b1;
    rAcc(15'h0003, 1'b1, 1'b1, 8'h00);
    runOp(OP_FLAG_TAKE, 15'h0003, 8'h00);
    check(st[ST_BIT_GRANT], 1'b0);
    check(rd[7:0], 8'hFF);
    rAcc(15'h0003, 1'b1, 1'b1, 8'h01);
    runOp(OP_FLAG_RD, 15'h0003, 8'h00);
    check(rd[7:0], 8'h00);
    rAcc(15'h0003, 1'b1, 1'b0, 8'h00);
    check(rSeen, 8'hFF);
    runOp(OP_FLAG_WR, 15'h0003, 8'h01);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    check({chipSelN, flagSelN, outEnN, readWriteN, dataOe, bvalid, rvalid}, 7'h78);
    rst_n <= 1'b1;
    runOp(OP_MEM_RD, 15'h0123, 8'h00);
    check(rd[7:0], 8'h99);
    give_verdict();
  end
endmodule : test_dual_port_mailbox_arbiter
`default_nettype wire
